/* rtl/eeac_pkg.sv */
// Constants and carrier types for the EEPROM control and access block
package eeac_pkg;
  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] OFS_CYCLE_CNT = 8'h88;
  localparam logic [7:0] OFS_MEM_CTRL  = 8'h89;
  localparam logic [7:0] OFS_LIVE_CRC  = 8'h8A;
  localparam logic [7:0] OFS_PTR_HIGH  = 8'h8B;
  localparam logic [7:0] OFS_PTR_LOW   = 8'h8C;
  localparam logic [7:0] OFS_EE_PORT   = 8'h8D;
  localparam logic [7:0] OFS_UNLOCK    = 8'h90;
  localparam logic [7:0] OFS_PAGE_SEL  = 8'h91;

  // ************************************************************
  // Control register fields and reset values
  // ************************************************************
  localparam int BIT_COPY     = 6;
  localparam int BIT_CRC_ERR  = 5;
  localparam int BIT_AUTO_CRC = 4;
  localparam int BIT_LOAD     = 3;
  localparam int BIT_BUSY     = 2;
  localparam int BIT_PROG     = 0;
  localparam logic       RST_AUTO_CRC = 1'b1;
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [7:0] UNLOCK_KEY   = 8'hEA;
  localparam logic [7:0] CNT_MAX      = 8'hFF;

  // ************************************************************
  // EEPROM layout and CRC
  // ************************************************************
  localparam logic [8:0] EE_LAST_BYTE = 9'h0FF;
  localparam logic [8:0] EE_CRC_BYTE  = 9'h004;
  localparam logic [8:0] EE_CNT_BYTE  = 9'h005;
  localparam logic [7:0] CRC_POLY     = 8'h07;
  localparam logic [7:0] CRC_INIT     = 8'h00;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_HZ       = 50_000_000;
  localparam int PROG_TIME_MS = 230;
  localparam int PROG_CYCLES  = PROG_TIME_MS * (CLK_HZ / 1000);

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } eeac_req_t;

  typedef struct packed {
    logic       ren;
    logic [8:0] addr;
  } eeac_ee_rd_t;

  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,
    S_LOAD  = 6'b000010,
    S_LDEND = 6'b000100,
    S_PROG  = 6'b001000,
    S_CNT   = 6'b010000,
    S_COPY  = 6'b100000
  } eeac_state_t;
endpackage

/* rtl/eeac_crc8.sv */
// One byte step of the EEPROM CRC
`timescale 1ns/1ns
`default_nettype none
module eeac_crc8
  import eeac_pkg::*;
(
  input  wire logic [7:0] crc_in,
  input  wire logic [7:0] data_in,
  output logic      [7:0] crc_out
);
  logic [7:0] c [0:8];
  assign c[0] = crc_in ^ data_in;
  // ************************************************************
  // Bitwise MSB-first division, one stage per bit
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bit
      assign c[g+1] = c[g][7] ? ({c[g][6:0], 1'b0} ^ CRC_POLY) : {c[g][6:0], 1'b0};
    end
  endgenerate
  assign crc_out = c[8];
endmodule
`default_nettype wire

/* rtl/eeac_top.sv */
// EEPROM control, status and indirect read access
//
// Notes on behaviour
// - Cycle counter adds one per program cycle, holding at 255.
// - Counter reloads from EEPROM after reset, load and program cycle.
// - Copy bit starts registers-to-SRAM copy of selected page; clears when done.
// - CRC mismatch during load sets the read-only CRC error flag.
// - Auto-CRC enable (reset 1) makes programming write the CRC byte.
// - EEPROM loads into registers after reset and on load bit; bit self-clears.
// - Register reads are not served while a load runs.
// - Load starts only while the always-on clock runs; keep-clock control exported.
// - Busy flag is 1 through a program cycle; EEPROM access blocked meanwhile.
// - Program bit starts a cycle only after key in preceding transaction.
// - A program cycle lasts about 230 ms.
// - Live CRC register shows the CRC computed while reading EEPROM.
// - Pointer is 12 bits: high nibble, then low byte, both reset zero.
// - EEPROM uses pointer bits 8..0; ROM uses all twelve bits.
// - First port read returns byte at pointer; later reads advance.
// - After first port access the register address holds until transaction end.
`timescale 1ns/1ns
`default_nettype none
module eeac_top
  import eeac_pkg::*;
#(
  parameter int PROG_WAIT = PROG_CYCLES
)(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire eeac_req_t   req,
  input  wire logic        txn_end,
  output logic             req_ready,
  output logic             rvalid,
  output logic [7:0]       rdata,
  output logic             addr_lock,
  output eeac_ee_rd_t      ee_rd,
  input  wire logic [7:0]  ee_rdata,
  output logic             ee_prog_start,
  output logic             ee_prog_auto_crc,
  output logic [7:0]       ee_prog_count,
  output logic             cfg_we,
  output logic [8:0]       cfg_idx,
  output logic [7:0]       cfg_data,
  output logic             copy_start,
  output logic [3:0]       copy_page,
  input  wire logic        copy_done,
  input  wire logic        aon_clk_running,
  input  wire logic        keep_aux_clock_after_lock_in,
  output logic             keep_aux_clock_after_lock,
  output logic [11:0]      memory_pointer
);
  // ************************************************************
  // State
  // ************************************************************
  eeac_state_t state_q;
  logic [7:0]  cnt_q, crc_q, stored_crc_q, unlock_q, ptr_lo_q, rdata_q;
  logic [3:0]  ptr_hi_q, page_q;
  logic        auto_crc_q, crc_err_q, load_pend_q, copy_pend_q;
  logic        armed_q, txn_key_q, lock_q, first_q;
  logic [8:0]  ee_cur_q, ld_idx_q, ld_didx_q;
  logic        ld_vld_q, rd_p1_q, rvalid_q;
  logic [7:0]  rd_addr_p1_q;
  logic [23:0] timer_q;
  logic [7:0]  crc_nxt, cnt_inc;
  logic        rd_go, wr_go, port_rd, prog_req;

  assign req_ready = (state_q != S_LOAD) && (state_q != S_LDEND);
  assign rd_go     = req.rd && req_ready;
  assign wr_go     = req.wr;
  assign port_rd   = rd_go && (req.addr == OFS_EE_PORT) && (state_q != S_PROG);
  assign prog_req  = wr_go && (req.addr == OFS_MEM_CTRL) && req.wdata[BIT_PROG];
  assign cnt_inc   = (cnt_q == CNT_MAX) ? CNT_MAX : cnt_q + 8'h01;
  assign memory_pointer = {ptr_hi_q, ptr_lo_q};
  assign keep_aux_clock_after_lock = keep_aux_clock_after_lock_in;

  eeac_crc8 u_crc (
    .crc_in  (crc_q),
    .data_in (ee_rdata),
    .crc_out (crc_nxt)
  );

  // ************************************************************
  // Sequencer: load, program, counter reload, copy
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= S_IDLE;
      ld_idx_q <= 9'h000;
      timer_q <= 24'h000000;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          ld_idx_q <= 9'h000;
          timer_q <= 24'h000000;
          if (prog_req && armed_q) state_q <= S_PROG;
          else if (load_pend_q && aon_clk_running) state_q <= S_LOAD;
          else if (copy_pend_q) state_q <= S_COPY;
        end
        S_LOAD: begin
          ld_idx_q <= ld_idx_q + 9'h001;
          if (ld_idx_q == EE_LAST_BYTE) state_q <= S_LDEND;
        end
        S_LDEND: state_q <= S_IDLE;
        S_PROG: begin
          timer_q <= timer_q + 24'h000001;
          if (timer_q == 24'(PROG_WAIT - 1)) state_q <= S_CNT;
        end
        S_CNT: state_q <= S_IDLE;
        S_COPY: if (copy_done) state_q <= S_IDLE;
      endcase
    end
  end

  // ************************************************************
  // EEPROM read requests and returning data
  // ************************************************************
  always_comb begin
    ee_rd.ren  = 1'b0;
    ee_rd.addr = 9'h000;
    if (state_q == S_LOAD) begin
      ee_rd.ren  = 1'b1;
      ee_rd.addr = ld_idx_q;
    end else if (state_q == S_CNT) begin
      ee_rd.ren  = 1'b1;
      ee_rd.addr = EE_CNT_BYTE;
    end else if (port_rd) begin
      ee_rd.ren  = 1'b1;
      ee_rd.addr = first_q ? {ptr_hi_q[0], ptr_lo_q} : ee_cur_q + 9'h001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ld_vld_q <= 1'b0;
      ld_didx_q <= 9'h000;
      ee_cur_q <= 9'h000;
    end else begin
      ld_vld_q <= (state_q == S_LOAD) || (state_q == S_CNT);
      ld_didx_q <= ee_rd.addr;
      if (port_rd) ee_cur_q <= ee_rd.addr;
    end
  end

  // Config register writes follow the load walk
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_we <= 1'b0;
      cfg_idx <= 9'h000;
      cfg_data <= RST_BYTE;
    end else begin
      cfg_we <= ld_vld_q && (state_q != S_IDLE);
      cfg_idx <= ld_didx_q;
      cfg_data <= ee_rdata;
    end
  end

  // ************************************************************
  // Counter, CRC and error
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_q <= RST_BYTE;
    end else if (ld_vld_q && (ld_didx_q == EE_CNT_BYTE)) begin
      cnt_q <= ee_rdata;
    end
  end

  // Stored CRC byte is left out of its own check
  always_ff @(posedge core_clk) begin
    if (srst) begin
      crc_q <= CRC_INIT;
      stored_crc_q <= RST_BYTE;
    end else if (state_q == S_IDLE && load_pend_q && aon_clk_running) begin
      crc_q <= CRC_INIT;
    end else if (ld_vld_q && state_q != S_IDLE && state_q != S_CNT) begin
      if (ld_didx_q == EE_CRC_BYTE) stored_crc_q <= ee_rdata;
      else crc_q <= crc_nxt;
    end
  end

  logic [7:0] live_crc_q;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      live_crc_q <= RST_BYTE;
      crc_err_q <= 1'b0;
    end else if (state_q == S_LDEND) begin
      live_crc_q <= crc_nxt;
      crc_err_q <= (crc_nxt != stored_crc_q);
    end
  end

  // ************************************************************
  // Program request, unlock tracking
  // ************************************************************
  // Key counts if the last write before transaction end carried it, or a write in the end cycle does
  always_ff @(posedge core_clk) begin
    if (srst) begin
      txn_key_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      if (txn_end) begin
        armed_q <= txn_key_q || (wr_go && req.addr == OFS_UNLOCK && req.wdata == UNLOCK_KEY);
        txn_key_q <= 1'b0;
      end else begin
        if (wr_go) txn_key_q <= (req.addr == OFS_UNLOCK) && (req.wdata == UNLOCK_KEY);
        if (prog_req) armed_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ee_prog_start <= 1'b0;
      ee_prog_count <= RST_BYTE;
    end else begin
      ee_prog_start <= (state_q == S_IDLE) && prog_req && armed_q;
      ee_prog_count <= cnt_inc;
    end
  end
  assign ee_prog_auto_crc = auto_crc_q;

  // ************************************************************
  // Software registers
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ptr_hi_q <= 4'h0;
      ptr_lo_q <= RST_BYTE;
      unlock_q <= RST_BYTE;
      page_q <= 4'h0;
      auto_crc_q <= RST_AUTO_CRC;
    end else if (wr_go) begin
      if (req.addr == OFS_PTR_HIGH) ptr_hi_q <= req.wdata[3:0];
      if (req.addr == OFS_PTR_LOW) ptr_lo_q <= req.wdata;
      if (req.addr == OFS_UNLOCK) unlock_q <= req.wdata;
      if (req.addr == OFS_PAGE_SEL) page_q <= req.wdata[3:0];
      if (req.addr == OFS_MEM_CTRL) auto_crc_q <= req.wdata[BIT_AUTO_CRC];
    end
  end

  // Pending bits: a new request wins over the clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      load_pend_q <= 1'b1;
      copy_pend_q <= 1'b0;
    end else begin
      if (wr_go && req.addr == OFS_MEM_CTRL && req.wdata[BIT_LOAD]) load_pend_q <= 1'b1;
      else if (state_q == S_LDEND) load_pend_q <= 1'b0;
      if (wr_go && req.addr == OFS_MEM_CTRL && req.wdata[BIT_COPY]) copy_pend_q <= 1'b1;
      else if (state_q == S_COPY && copy_done) copy_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      copy_start <= 1'b0;
      copy_page <= 4'h0;
    end else begin
      copy_start <= (state_q == S_IDLE) && copy_pend_q && !(prog_req && armed_q)
                    && !(load_pend_q && aon_clk_running);
      copy_page <= page_q;
    end
  end

  // ************************************************************
  // Port address lock and read answers
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lock_q <= 1'b0;
      first_q <= 1'b1;
    end else if (txn_end) begin
      lock_q <= 1'b0;
      first_q <= 1'b1;
    end else if (rd_go && req.addr == OFS_EE_PORT) begin
      lock_q <= 1'b1;
      if (port_rd) first_q <= 1'b0;
    end
  end
  assign addr_lock = lock_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_p1_q <= 1'b0;
      rd_addr_p1_q <= RST_BYTE;
      rvalid_q <= 1'b0;
      rdata_q <= RST_BYTE;
    end else begin
      rd_p1_q <= rd_go;
      rd_addr_p1_q <= req.addr;
      rvalid_q <= rd_p1_q;
      unique case (rd_addr_p1_q)
        OFS_CYCLE_CNT: rdata_q <= cnt_q;
        OFS_MEM_CTRL:  rdata_q <= {1'b0, copy_pend_q, crc_err_q, auto_crc_q,
                                   load_pend_q, (state_q == S_PROG), 2'b00};
        OFS_LIVE_CRC:  rdata_q <= live_crc_q;
        OFS_PTR_HIGH:  rdata_q <= {4'h0, ptr_hi_q};
        OFS_PTR_LOW:   rdata_q <= ptr_lo_q;
        OFS_EE_PORT:   rdata_q <= (state_q == S_PROG) ? RST_BYTE : ee_rdata;
        OFS_UNLOCK:    rdata_q <= unlock_q;
        OFS_PAGE_SEL:  rdata_q <= {4'h0, page_q};
        default:       rdata_q <= RST_BYTE;
      endcase
    end
  end
  assign rvalid = rvalid_q;
  assign rdata  = rdata_q;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_prog_go;
    (state_q == S_IDLE) && prog_req && armed_q;
  endsequence
  sequence s_cnt_back;
    state_q == S_CNT ##1 state_q == S_IDLE;
  endsequence

  chk_count_saturates: assert property ((cnt_q == CNT_MAX) |=> ee_prog_count == CNT_MAX)
    else $error("count passed its maximum");
  chk_count_reload: assert property (s_cnt_back |=> cnt_q == $past(ee_rdata))
    else $error("count not reloaded after program");
  chk_copy_clear: assert property ((state_q == S_COPY && copy_done && !(wr_go && req.addr == OFS_MEM_CTRL && req.wdata[BIT_COPY])) |=> !copy_pend_q)
    else $error("copy bit did not clear");
  chk_crc_error: assert property ((state_q == S_LDEND && crc_nxt != stored_crc_q) |=> crc_err_q)
    else $error("crc mismatch not flagged");
  chk_no_read_load: assert property ((state_q == S_LOAD && req.rd) |-> ##2 !rvalid)
    else $error("read served during load");
  chk_load_clock: assert property ((state_q == S_IDLE ##1 state_q == S_LOAD) |-> $past(aon_clk_running))
    else $error("load started without always-on clock");
  chk_busy_blocks: assert property ((state_q == S_PROG) |-> !ee_rd.ren)
    else $error("eeprom accessed while busy");
  chk_prog_unlock: assert property (s_prog_go |=> ee_prog_start && state_q == S_PROG)
    else $error("program not started after unlock");
  chk_prog_locked: assert property ((state_q == S_IDLE ##1 state_q == S_PROG) |-> $past(armed_q))
    else $error("program started without key");
  chk_port_lock: assert property ((rd_go && req.addr == OFS_EE_PORT && !txn_end) |=> addr_lock)
    else $error("address not locked on port");
  chk_first_byte: assert property ((port_rd && first_q) |-> ee_rd.addr == memory_pointer[8:0])
    else $error("first port read not at pointer");
endmodule
`default_nettype wire

/* test/eeac_ee_model.sv */
// Behavioural EEPROM macro and SRAM copy engine facing the block
`timescale 1ns/1ns
`default_nettype none
module eeac_ee_model
  import eeac_pkg::*;
(
  input  wire logic        core_clk,
  input  wire eeac_ee_rd_t ee_rd,
  output logic [7:0]       ee_rdata,
  input  wire logic        ee_prog_start,
  input  wire logic        ee_prog_auto_crc,
  input  wire logic [7:0]  ee_prog_count,
  input  wire logic        copy_start,
  input  wire logic [3:0]  copy_page,
  output logic             copy_done
);
  logic [7:0] mem [512];
  logic [3:0] page_q = 4'h0;
  int         wait_n = 0;

  // CRC over the load range, stored CRC byte skipped
  function automatic logic [7:0] crc_all();
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 256; i++) begin
      if (i != 4) begin
        c = c ^ mem[i];
        for (int b = 0; b < 8; b++) begin
          c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
        end
      end
    end
    return c;
  endfunction

  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = 8'(i) ^ 8'h5C;
    end
    mem[5] = 8'hFE;
    mem[4] = crc_all();
    ee_rdata = 8'h00;
    copy_done = 1'b0;
  end

  // Data valid one cycle after ren; inverted otherwise so stale reads show
  always @(posedge core_clk) begin
    ee_rdata <= (ee_rd.ren === 1'b1) ? mem[ee_rd.addr] : ~ee_rdata;
    if (ee_prog_start === 1'b1) begin
      mem[5] = ee_prog_count;
      if (ee_prog_auto_crc === 1'b1) begin
        mem[4] = crc_all();
      end
    end
  end

  // Copy lasts a few cycles so the self-clearing bit can be seen
  always @(posedge core_clk) begin
    copy_done <= (wait_n == 1);
    if (copy_start === 1'b1) begin
      page_q <= copy_page;
      wait_n <= 6;
    end else if (wait_n > 0) begin
      wait_n <= wait_n - 1;
    end
  end
endmodule
`default_nettype wire

/* test/eeac_top_bench.sv */
// Self-checking bench for the EEPROM control and access block
`timescale 1ns/1ns
`default_nettype none
module eeac_top_bench
  import eeac_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  eeac_req_t   req = '0;
  logic        txn_end = 1'b0;
  logic        aon_clk_running = 1'b1;
  logic        keep_aux_clock_after_lock_in = 1'b1;
  logic        req_ready, rvalid, addr_lock, ee_prog_start, ee_prog_auto_crc;
  logic        copy_start, copy_done, keep_aux_clock_after_lock, cfg_we;
  logic [7:0]  rdata, ee_rdata, ee_prog_count;
  logic [3:0]  copy_page;
  logic [11:0] memory_pointer;
  logic [8:0]  cfg_idx;
  logic [7:0]  cfg_data;
  int          cfg_bad = 0;
  eeac_ee_rd_t ee_rd;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          we_cnt = 0;
  int          rv_cnt = 0;

  always #10 core_clk = ~core_clk;

  eeac_top #(.PROG_WAIT(20)) i_dut (
    .core_clk, .srst, .req, .txn_end, .req_ready, .rvalid, .rdata, .addr_lock,
    .ee_rd, .ee_rdata, .ee_prog_start, .ee_prog_auto_crc, .ee_prog_count,
    .cfg_we, .cfg_idx, .cfg_data, .copy_start, .copy_page, .copy_done,
    .aon_clk_running, .keep_aux_clock_after_lock_in, .keep_aux_clock_after_lock,
    .memory_pointer
  );

  eeac_ee_model i_ee (
    .core_clk, .ee_rd, .ee_rdata, .ee_prog_start, .ee_prog_auto_crc,
    .ee_prog_count, .copy_start, .copy_page, .copy_done
  );

  always @(posedge core_clk) begin
    if (cfg_we === 1'b1) we_cnt++;
    if (cfg_we === 1'b1 && cfg_data !== i_ee.mem[cfg_idx]) cfg_bad++;
    if (rvalid === 1'b1) rv_cnt++;
  end

  // ************************************************************
  // Access tasks and comparisons
  // ************************************************************
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = v;
    @(negedge core_clk);
    req.wr = 1'b0;
    @(negedge core_clk);
  endtask

  // Waits out a running load, since reads are dropped while it runs
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 600) begin
      @(negedge core_clk);
      n++;
    end
    req.rd = 1'b1;
    req.addr = a;
    @(negedge core_clk);
    req.rd = 1'b0;
    n = 0;
    while (rvalid !== 1'b1 && n < 4) begin
      @(negedge core_clk);
      n++;
    end
    if (rvalid !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: no read answer", $time);
    end
    d = rdata;
  endtask

  task automatic txn();
    txn_end = 1'b1;
    @(negedge core_clk);
    txn_end = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic stop_test();
    $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    $display("CHECK FAILED at %0t: run timed out", $time);
    error_cnt++;
    stop_test();
  end

  initial begin
    logic [7:0] d;
    int         n;
    repeat (16) @(negedge core_clk);
    srst = 1'b0;
    repeat (3) @(negedge core_clk);
    chk_bit(req_ready, 1'b0);
    rd(OFS_MEM_CTRL, d);
    chk_val(d, 8'h10);
    chk_bit(we_cnt == 256, 1'b1);
    rd(OFS_CYCLE_CNT, d);
    chk_val(d, 8'hFE);
    rd(OFS_LIVE_CRC, d);
    chk_val(d, i_ee.crc_all());
    rd(OFS_PTR_HIGH, d);
    chk_val(d, 8'h00);
    rd(OFS_PTR_LOW, d);
    chk_val(d, 8'h00);
    chk_bit(keep_aux_clock_after_lock, 1'b1);
    wr(OFS_PTR_HIGH, 8'h01);
    wr(OFS_PTR_LOW, 8'h23);
    chk_val(memory_pointer[7:0], 8'h23);
    chk_val({4'h0, memory_pointer[11:8]}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      rd(OFS_EE_PORT, d);
      chk_val(d, i_ee.mem[9'h123 + i]);
    end
    chk_bit(addr_lock, 1'b1);
    txn();
    @(negedge core_clk);
    chk_bit(addr_lock, 1'b0);
    rd(OFS_EE_PORT, d);
    chk_val(d, i_ee.mem[9'h123]);
    txn();
    // Wrong key, then a right key no longer in the preceding transaction
    for (int k = 0; k < 2; k++) begin
      wr(OFS_UNLOCK, (k == 0) ? 8'hEB : UNLOCK_KEY);
      txn();
      if (k == 1) begin
        wr(OFS_PTR_LOW, 8'h23);
        txn();
      end
      wr(OFS_MEM_CTRL, 8'h11);
      txn();
      rd(OFS_MEM_CTRL, d);
      chk_val(d, 8'h10);
    end
    // Second cycle meets a saturated count
    for (int k = 0; k < 2; k++) begin
      wr(OFS_UNLOCK, UNLOCK_KEY);
      txn();
      wr(OFS_MEM_CTRL, 8'h11);
      txn();
      rd(OFS_MEM_CTRL, d);
      chk_bit(d[2], 1'b1);
      rd(OFS_EE_PORT, d);
      chk_val(d, 8'h00);
      txn();
      d = 8'hFF;
      n = 0;
      while (d[2] !== 1'b0 && n < 50) begin
        rd(OFS_MEM_CTRL, d);
        n++;
      end
      chk_val(d, 8'h10);
      rd(OFS_CYCLE_CNT, d);
      chk_val(d, 8'hFF);
      chk_val(i_ee.mem[4], i_ee.crc_all());
    end
    for (int p = 0; p < 6; p++) begin
      wr(OFS_PAGE_SEL, 8'(p));
      wr(OFS_MEM_CTRL, 8'h50);
      rd(OFS_MEM_CTRL, d);
      chk_bit(d[6], 1'b1);
      repeat (10) @(negedge core_clk);
      rd(OFS_MEM_CTRL, d);
      chk_val(d, 8'h10);
      chk_val({4'h0, i_ee.page_q}, 8'(p));
    end
    // Count byte altered without its CRC, load held off by a stopped clock
    i_ee.mem[5] = 8'h10;
    aon_clk_running = 1'b0;
    we_cnt = 0;
    wr(OFS_MEM_CTRL, 8'h18);
    repeat (10) @(negedge core_clk);
    chk_bit(req_ready, 1'b1);
    chk_bit(we_cnt == 0, 1'b1);
    aon_clk_running = 1'b1;
    repeat (3) @(negedge core_clk);
    chk_bit(req_ready, 1'b0);
    rv_cnt = 0;
    req.rd = 1'b1;
    req.addr = OFS_CYCLE_CNT;
    @(negedge core_clk);
    req.rd = 1'b0;
    repeat (3) @(negedge core_clk);
    chk_bit(rv_cnt == 0, 1'b1);
    rd(OFS_MEM_CTRL, d);
    chk_val(d, 8'h30);
    rd(OFS_CYCLE_CNT, d);
    chk_val(d, 8'h10);
    rd(OFS_LIVE_CRC, d);
    chk_val(d, i_ee.crc_all());
    chk_bit(we_cnt == 256, 1'b1);
    chk_bit(cfg_bad == 0, 1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
